// ### bench/cctd_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t %h %h", $time, g, e); end end
module cctd_decoder_tb;
  logic pclk, presetn, psel, penable, pwrite, slow, pready, pslverr, se;
  logic ib_valid, ib_ready, bus_lock, ext_handoff, sw_int_req, done;
  logic [7:0] paddr, ib_byte, sw_int_vec;
  logic [31:0] pwdata, prdata, rd;
  int fails = 0;
  int tests_run = 0;
  // opcode, flags, count, taken
  localparam logic [43:0] T[22] = '{44'h74004000001, 44'h75004000000, 44'h78008000001, 44'h79000000001,
    44'h70080000001, 44'h72000100001, 44'h73000100000, 44'h77000000001, 44'h77004000000, 44'h7D088000001,
    44'h7D008000000, 44'h7F000000001, 44'h7F004000000, 44'h7A000400001, 44'h7B000400000, 44'hEB000000001,
    44'hE2000000021, 44'hE2000000010, 44'hE1004000021, 44'hE0004000020, 44'hE3000000001, 44'hE3000000010};
  // register preload: address, value
  localparam logic [23:0] S[6] = '{24'h080200, 24'h240305, 24'h2C0010, 24'h380020, 24'h341000, 24'h300100};
  // bytes, count, read address, expected
  localparam logic [79:0] U[16] = '{80'hF9000000_01_08_00000201, 80'hF5000000_01_08_00000200,
    80'hFA000000_01_08_00000000, 80'hD846FC00_03_10_00000FFC, 80'hD8063412_04_10_00001234,
    80'hD8800001_04_10_00000130, 80'h83C0FF00_03_18_0000FFFF, 80'h81C03412_04_18_00001234,
    80'hD3E00000_02_18_00000005, 80'hD1E00000_02_18_00000001, 80'hC2040000_03_30_00000106,
    80'hC3000000_01_30_00000108, 80'hCD210000_02_18_00000021, 80'hCC000000_01_18_00000003,
    80'h00E80000_02_1C_00000003, 80'h01E80000_02_1C_00001000};
  cctd_decoder u_cctd_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ib_valid(ib_valid),
    .ib_byte(ib_byte), .ib_ready(ib_ready), .bus_lock(bus_lock), .ext_handoff(ext_handoff),
    .sw_int_req(sw_int_req), .sw_int_vec(sw_int_vec), .done(done));
  cctd_mem u_cctd_mem (.pclk(pclk), .ib_ready(ib_ready), .slow(slow), .ib_valid(ib_valid), .ib_byte(ib_byte));
  // one apb transfer: setup, access until pready at a rising edge, then an idle cycle
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // feed n bytes, wait for completion
  task automatic ex(input logic [31:0] b, input int n);
    @(negedge pclk);
    for (int k = 0; k < n; k++) u_cctd_mem.push(b[31 - 8 * k -: 8]);
    while (done !== 1'b1) @(negedge pclk);
    @(posedge pclk);
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    fails++;
    summarize();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(cctd_pkg::REG_STATUS, 1'b0, 32'h0);
    `CK(rd, 32'h0)
    apb(8'h40, 1'b0, 32'h0);
    `CK(se, 1'b1)
    apb(8'h06, 1'b0, 32'h0);
    `CK(se, 1'b1)
    apb(cctd_pkg::REG_CTRL, 1'b1, 32'h1);
    // branches with a backward displacement
    foreach (T[i])
    begin
      apb(cctd_pkg::REG_IP, 1'b1, 32'h100);
      apb(cctd_pkg::REG_FLAGS, 1'b1, {16'h0, T[i][35:20]});
      apb(8'h24, 1'b1, {16'h0, T[i][19:4]});
      slow <= i[0];
      ex({T[i][43:36], 8'hFE, 16'h0}, 2);
      apb(cctd_pkg::REG_IP, 1'b0, 32'h0);
      `CK(rd, T[i][0] ? 32'h100 : 32'h102)
    end
    foreach (S[i]) apb(S[i][23:16], 1'b1, {16'h0, S[i][15:0]});
    // decode then read one result register
    foreach (U[i])
    begin
      ex(U[i][79:48], U[i][47:40]);
      apb(U[i][39:32], 1'b0, 32'h0);
      `CK(rd, U[i][31:0])
    end
    `CK(sw_int_vec, 8'h03)
    ex(32'h2ED8C000, 3);
    apb(cctd_pkg::REG_STATUS, 1'b0, 32'h0);
    `CK(rd[8:6], 3'b011)
    ex(32'hF0F90000, 2);
    apb(cctd_pkg::REG_STATUS, 1'b0, 32'h0);
    `CK(rd[5], 1'b1)
    ex(32'h02E80000, 2);
    apb(cctd_pkg::REG_STATUS, 1'b0, 32'h0);
    `CK(rd[10:9], 2'b10)
    summarize();
  end
endmodule
`default_nettype wire

// ### bench/cctd_mem.sv
`timescale 1ns/1ns
`default_nettype none
module cctd_mem (
  input wire logic pclk,
  input wire logic ib_ready,
  input wire logic slow,
  output logic ib_valid,
  output logic [7:0] ib_byte
);
  logic [7:0] q[$];
  initial ib_valid = 1'b0;
  initial ib_byte = 8'h00;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // offer queue head; slow idles a cycle per byte; idle byte toggles
  always @(posedge pclk)
  begin
    if (ib_valid && ib_ready)
      void'(q.pop_front());
    ib_valid <= q.size() > 0 && !(slow && ib_valid && ib_ready);
    ib_byte <= (q.size() > 0) ? q[0] : ~ib_byte;
  end
endmodule
`default_nettype wire

// ### bench/cctd_properties.sv
`timescale 1ns/1ns
`default_nettype none
module cctd_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ib_valid,
  input wire logic ib_ready,
  input wire logic [7:0] ib_byte,
  input wire logic bus_lock,
  input wire logic ext_handoff,
  input wire logic sw_int_req,
  input wire logic done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer shape
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long pready");
  property p_err; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no pslverr");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("prdata idle");
  // completion pulses
  property p_done; done |=> !done; endproperty
  a_done: assert property (p_done) else $error("long done");
  property p_esc; ext_handoff |-> done; endproperty
  a_esc: assert property (p_esc) else $error("handoff");
  property p_int; sw_int_req |-> done ##1 !sw_int_req; endproperty
  a_int: assert property (p_int) else $error("int pulse");
  property p_lock; $rose(bus_lock) |-> $past(ib_valid && ib_ready && ib_byte == 8'hF0); endproperty
  a_lock: assert property (p_lock) else $error("lock");
  c_int: cover property (sw_int_req);
  c_esc: cover property (ext_handoff);
  c_lock: cover property (bus_lock ##1 done);
endmodule
bind cctd_decoder cctd_properties u_cctd_properties (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ib_valid(ib_valid), .ib_ready(ib_ready),
  .ib_byte(ib_byte), .bus_lock(bus_lock), .ext_handoff(ext_handoff), .sw_int_req(sw_int_req), .done(done));
`default_nettype wire

// ### hw/cctd_decoder.sv
// Notes on behaviour
// - 74h branches on zero set, 75h on zero clear, one displacement byte.
// - 78h sign set, 79h sign clear, 70h overflow set, each one-byte displacement.
// - 72h below (carry), 73h not below, 77h above (carry and zero clear).
// - 7Dh not-less (sign equals overflow), 7Fh greater (not-less, zero clear).
// - 7Ah branches on even parity, 7Bh on odd parity.
// - loops decrement count; E2h nonzero, E1h also zero set, E0h zero clear.
// - E3h branches only when the count register is zero.
// - CDh vector from next byte, CCh vector 3, CEh only on overflow.
// - F5h complements carry, F9h sets carry, FAh clears interrupt enable.
// - F0h prefix locks the bus for the following instruction.
// - D8h-DFh plus addressing byte hand off externally with operand address.
// - EBh jumps unconditionally by one displacement byte.
// - C3h returns; immediate variants add the low-first 16-bit value to stack.
// - width bit 1 means word, direction bit 1 makes reg the destination.
// - mode 11 register, 00 no disp, 01 sign-extended byte, 10 word disp.
// - r/m selects the base and index pair of the effective address.
// - mode 00 with r/m 110 uses a direct 16-bit address.
// - sign/width 01 takes two immediate bytes, 11 sign-extends one byte.
// - shift count is one when select bit 0, count low byte when 1.
// - 001 sr 110 prefix overrides segment: extra, code, stack, data.
// - register codes map to word registers or low and high byte halves.
// - flag word holds carry, parity, aux, zero, sign, trap, ie, dir, overflow.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cctd_decoder #(
  parameter logic [7:0] OVF_VEC = 8'h04
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ib_valid,
  input wire logic [7:0] ib_byte,
  output logic ib_ready,
  output logic bus_lock,
  output logic ext_handoff,
  output logic sw_int_req,
  output logic [7:0] sw_int_vec,
  output logic done
);

  cctd_pkg::cctd_state_t state_r;
  cctd_pkg::cctd_state_t state_nxt;
  cctd_pkg::cctd_opinfo_t info;
  cctd_pkg::cctd_status_t status_r;
  cctd_pkg::cctd_kind_t kind_r;
  logic [15:0] gpr_r [8];
  logic [15:0] ip_r;
  logic [15:0] flags_r;
  logic run_r;
  logic [7:0] op_r;
  logic [7:0] modrm_r;
  logic [15:0] disp_r;
  logic [15:0] imm_r;
  logic [1:0] imm_n_r;
  logic [15:0] ilen_r;
  logic lock_pend_r;
  logic seg_pend_r;
  logic [1:0] seg_code_r;
  logic [15:0] ea_r;
  logic [15:0] target_r;
  logic [15:0] operand_r;
  logic [15:0] regval_r;
  logic take;
  logic is_prefix;
  logic is_seg;
  logic exec;
  logic ex_taken;
  logic [15:0] ex_ip;
  logic [15:0] ex_operand;
  logic [15:0] ip_next;
  logic [15:0] rel;
  logic [15:0] count_dec;
  logic apb_wr;
  logic [2:0] gpr_idx;
  logic gpr_hit;

  // classify an opcode byte by what must follow it
  function automatic cctd_pkg::cctd_opinfo_t op_info(input logic [7:0] op);
    cctd_pkg::cctd_opinfo_t r;
    r = '{has_modrm: 1'b0, imm_n: 2'd0, kind: cctd_pkg::K_UNKNOWN};
    if (op[7:4] == 4'h7)
      r = '{has_modrm: 1'b0, imm_n: 2'd1, kind: cctd_pkg::K_JCC};
    else if (op == cctd_pkg::OP_LOOP || op == cctd_pkg::OP_LOOP_EQ || op == cctd_pkg::OP_LOOP_NE)
      r = '{has_modrm: 1'b0, imm_n: 2'd1, kind: cctd_pkg::K_LOOP};
    else if (op == cctd_pkg::OP_JCXZ)
      r = '{has_modrm: 1'b0, imm_n: 2'd1, kind: cctd_pkg::K_JCXZ};
    else if (op == cctd_pkg::OP_INT_N)
      r = '{has_modrm: 1'b0, imm_n: 2'd1, kind: cctd_pkg::K_INT};
    else if (op == cctd_pkg::OP_INT_3 || op == cctd_pkg::OP_INT_OVF)
      r = '{has_modrm: 1'b0, imm_n: 2'd0, kind: cctd_pkg::K_INT};
    else if (op == cctd_pkg::OP_JMP_SHORT)
      r = '{has_modrm: 1'b0, imm_n: 2'd1, kind: cctd_pkg::K_JMPS};
    else if (op == cctd_pkg::OP_RETURN)
      r = '{has_modrm: 1'b0, imm_n: 2'd0, kind: cctd_pkg::K_RETURN};
    else if (op == cctd_pkg::OP_RETURN_IMM || op == cctd_pkg::OP_RETURN_FAR_IMM)
      r = '{has_modrm: 1'b0, imm_n: 2'd2, kind: cctd_pkg::K_RETURN};
    else if (op == cctd_pkg::OP_CARRY_CPL || op == cctd_pkg::OP_CARRY_SET || op == cctd_pkg::OP_IE_CLEAR)
      r = '{has_modrm: 1'b0, imm_n: 2'd0, kind: cctd_pkg::K_FLAG};
    else if (op[7:3] == 5'b11011)
      r = '{has_modrm: 1'b1, imm_n: 2'd0, kind: cctd_pkg::K_HANDOFF};
    else if (op[7:2] == 6'b100000)
      r = '{has_modrm: 1'b1, imm_n: (op[1:0] == 2'b01) ? 2'd2 : 2'd1, kind: cctd_pkg::K_IMMGRP};
    else if (op[7:2] == 6'b110100)
      r = '{has_modrm: 1'b1, imm_n: 2'd0, kind: cctd_pkg::K_SHIFT};
    else if (op[7:6] == 2'b00 && op[2] == 1'b0)
      r = '{has_modrm: 1'b1, imm_n: 2'd0, kind: cctd_pkg::K_ALU};
    return r;
  endfunction

  // displacement bytes that follow an addressing byte
  function automatic logic [1:0] disp_n(input logic [7:0] m);
    if (m[7:6] == 2'b00 && m[2:0] == 3'b110)
      return 2'd2;
    else if (m[7:6] == 2'b01)
      return 2'd1;
    else if (m[7:6] == 2'b10)
      return 2'd2;
    return 2'd0;
  endfunction

  // condition of a short conditional branch from the low opcode nibble
  function automatic logic cond_met(input logic [3:0] c, input logic [15:0] f);
    logic r;
    r = 1'b0;
    unique case (c[3:1])
      3'd0: r = f[cctd_pkg::FLG_OVF];
      3'd1: r = f[cctd_pkg::FLG_CARRY];
      3'd2: r = f[cctd_pkg::FLG_ZERO];
      3'd3: r = f[cctd_pkg::FLG_CARRY] | f[cctd_pkg::FLG_ZERO];
      3'd4: r = f[cctd_pkg::FLG_SIGN];
      3'd5: r = f[cctd_pkg::FLG_PARITY];
      3'd6: r = f[cctd_pkg::FLG_SIGN] ^ f[cctd_pkg::FLG_OVF];
      3'd7: r = (f[cctd_pkg::FLG_SIGN] ^ f[cctd_pkg::FLG_OVF]) | f[cctd_pkg::FLG_ZERO];
    endcase
    return r ^ c[0];
  endfunction

  // operand of a register field, word or byte half
  function automatic logic [15:0] reg_read(input logic [2:0] code, input logic w, input logic [15:0] v_w,
                                           input logic [15:0] v_b);
    if (w)
      return v_w;
    return code[2] ? {8'h00, v_b[15:8]} : {8'h00, v_b[7:0]};
  endfunction

  // handshake and control strobes
  assign take = ib_valid & ib_ready;
  assign exec = (state_r == cctd_pkg::ST_EXEC);
  assign is_seg = (ib_byte[7:5] == 3'b001) && (ib_byte[2:0] == 3'b110);
  assign is_prefix = (ib_byte == cctd_pkg::OP_LOCK) | is_seg;
  assign info = op_info(ib_byte);
  assign apb_wr = psel & penable & pready & pwrite;
  assign gpr_hit = (paddr >= cctd_pkg::REG_GPR_BASE) && (paddr <= cctd_pkg::REG_GPR_LAST) && (paddr[1:0] == 2'b00);
  assign gpr_idx = paddr[4:2];

  // next decoder state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      cctd_pkg::ST_OPCODE:
        if (take && !is_prefix)
          state_nxt = info.has_modrm ? cctd_pkg::ST_MODRM
                    : (info.imm_n != 2'd0) ? cctd_pkg::ST_IMM_LO : cctd_pkg::ST_EXEC;
      cctd_pkg::ST_MODRM:
        if (take)
          state_nxt = (disp_n(ib_byte) != 2'd0) ? cctd_pkg::ST_DISP_LO
                    : (imm_n_r != 2'd0) ? cctd_pkg::ST_IMM_LO : cctd_pkg::ST_EXEC;
      cctd_pkg::ST_DISP_LO:
        if (take)
          state_nxt = (disp_n(modrm_r) == 2'd2) ? cctd_pkg::ST_DISP_HI
                    : (imm_n_r != 2'd0) ? cctd_pkg::ST_IMM_LO : cctd_pkg::ST_EXEC;
      cctd_pkg::ST_DISP_HI:
        if (take)
          state_nxt = (imm_n_r != 2'd0) ? cctd_pkg::ST_IMM_LO : cctd_pkg::ST_EXEC;
      cctd_pkg::ST_IMM_LO:
        if (take)
          state_nxt = (imm_n_r == 2'd2) ? cctd_pkg::ST_IMM_HI : cctd_pkg::ST_EXEC;
      cctd_pkg::ST_IMM_HI:
        if (take)
          state_nxt = cctd_pkg::ST_EXEC;
      cctd_pkg::ST_EXEC:
        state_nxt = cctd_pkg::ST_OPCODE;
      default:
        state_nxt = cctd_pkg::ST_OPCODE;
    endcase
  end

  // decoder state and byte-stream ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= cctd_pkg::ST_OPCODE;
      ib_ready <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ib_ready <= run_r & (state_nxt != cctd_pkg::ST_EXEC);
    end
  end

  // capture of opcode, addressing byte, displacement and immediate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_r <= 8'h00;
      modrm_r <= 8'h00;
      disp_r <= cctd_pkg::RST_WORD;
      imm_r <= cctd_pkg::RST_WORD;
      imm_n_r <= 2'd0;
      kind_r <= cctd_pkg::K_NONE;
      ilen_r <= cctd_pkg::RST_WORD;
    end
    else if (exec)
      ilen_r <= cctd_pkg::RST_WORD;
    else if (take)
    begin
      ilen_r <= ilen_r + 16'h0001;
      unique case (state_r)
        cctd_pkg::ST_OPCODE:
          if (!is_prefix)
          begin
            op_r <= ib_byte;
            imm_n_r <= info.imm_n;
            kind_r <= info.kind;
            modrm_r <= 8'h00;
            disp_r <= cctd_pkg::RST_WORD;
            imm_r <= cctd_pkg::RST_WORD;
          end
        cctd_pkg::ST_MODRM: modrm_r <= ib_byte;
        cctd_pkg::ST_DISP_LO: disp_r <= {{8{ib_byte[7]}}, ib_byte};
        cctd_pkg::ST_DISP_HI: disp_r[15:8] <= ib_byte;
        cctd_pkg::ST_IMM_LO: imm_r <= {{8{ib_byte[7]}}, ib_byte};
        cctd_pkg::ST_IMM_HI: imm_r[15:8] <= ib_byte;
        default: ;
      endcase
    end
  end

  // prefixes held for the next instruction, and the bus lock output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_pend_r <= 1'b0;
      seg_pend_r <= 1'b0;
      seg_code_r <= 2'b00;
      bus_lock <= 1'b0;
    end
    else if (exec)
    begin
      lock_pend_r <= 1'b0;
      seg_pend_r <= 1'b0;
      bus_lock <= 1'b0;
    end
    else if (take && state_r == cctd_pkg::ST_OPCODE)
    begin
      if (ib_byte == cctd_pkg::OP_LOCK)
      begin
        lock_pend_r <= 1'b1;
        bus_lock <= 1'b1;
      end
      if (is_seg)
      begin
        seg_pend_r <= 1'b1;
        seg_code_r <= ib_byte[4:3];
      end
    end
  end

  // execution of the completed instruction
  assign ip_next = ip_r + ilen_r;
  assign rel = ip_next + imm_r;
  assign count_dec = gpr_r[cctd_pkg::RC_COUNT] - 16'h0001;

  always_comb
  begin
    ex_taken = 1'b0;
    ex_operand = imm_r;
    unique case (kind_r)
      cctd_pkg::K_JCC: ex_taken = cond_met(op_r[3:0], flags_r);
      cctd_pkg::K_LOOP:
        if (op_r == cctd_pkg::OP_LOOP_EQ)
          ex_taken = (count_dec != 16'h0000) & flags_r[cctd_pkg::FLG_ZERO];
        else if (op_r == cctd_pkg::OP_LOOP_NE)
          ex_taken = (count_dec != 16'h0000) & ~flags_r[cctd_pkg::FLG_ZERO];
        else
          ex_taken = (count_dec != 16'h0000);
      cctd_pkg::K_JCXZ: ex_taken = (gpr_r[cctd_pkg::RC_COUNT] == 16'h0000);
      cctd_pkg::K_JMPS: ex_taken = 1'b1;
      cctd_pkg::K_RETURN: ex_taken = 1'b1;
      cctd_pkg::K_INT:
        if (op_r == cctd_pkg::OP_INT_N)
        begin
          ex_taken = 1'b1;
          ex_operand = {8'h00, imm_r[7:0]};
        end
        else if (op_r == cctd_pkg::OP_INT_3)
        begin
          ex_taken = 1'b1;
          ex_operand = {8'h00, cctd_pkg::INT3_VECTOR};
        end
        else
        begin
          ex_taken = flags_r[cctd_pkg::FLG_OVF];
          ex_operand = {8'h00, OVF_VEC};
        end
      cctd_pkg::K_SHIFT:
        ex_operand = op_r[1] ? {8'h00, gpr_r[cctd_pkg::RC_COUNT][7:0]} : cctd_pkg::SHIFT_ONE;
      default: ;
    endcase
    ex_ip = ip_next;
    if (ex_taken && (kind_r == cctd_pkg::K_JCC || kind_r == cctd_pkg::K_LOOP ||
                     kind_r == cctd_pkg::K_JCXZ || kind_r == cctd_pkg::K_JMPS))
      ex_ip = rel;
  end

  // control, instruction pointer and flag word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_r <= cctd_pkg::RST_RUN;
      ip_r <= cctd_pkg::RST_WORD;
      flags_r <= cctd_pkg::RST_WORD;
    end
    else
    begin
      if (apb_wr && paddr == cctd_pkg::REG_CTRL)
        run_r <= pwdata[0];
      // a software write beats the decoder only on the register it addresses
      if (apb_wr && paddr == cctd_pkg::REG_IP)
        ip_r <= pwdata[15:0];
      else if (exec)
        ip_r <= ex_ip;
      if (apb_wr && paddr == cctd_pkg::REG_FLAGS)
        flags_r <= pwdata[15:0] & cctd_pkg::FLAG_MASK;
      else if (exec)
      begin
        if (op_r == cctd_pkg::OP_CARRY_CPL)
          flags_r[cctd_pkg::FLG_CARRY] <= ~flags_r[cctd_pkg::FLG_CARRY];
        else if (op_r == cctd_pkg::OP_CARRY_SET)
          flags_r[cctd_pkg::FLG_CARRY] <= 1'b1;
        else if (op_r == cctd_pkg::OP_IE_CLEAR)
          flags_r[cctd_pkg::FLG_IE] <= 1'b0;
      end
    end
  end

  // general registers: software writes, loop count and stack adjust
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        gpr_r[i] <= cctd_pkg::RST_WORD;
    end
    else
    begin
      // decoder update first; a software write to the same register lands last and wins
      if (exec && kind_r == cctd_pkg::K_LOOP)
        gpr_r[cctd_pkg::RC_COUNT] <= count_dec;
      else if (exec && kind_r == cctd_pkg::K_RETURN)
        gpr_r[cctd_pkg::RC_STACK] <= gpr_r[cctd_pkg::RC_STACK] + cctd_pkg::POP_BYTES + imm_r;
      if (apb_wr && gpr_hit)
        gpr_r[gpr_idx] <= pwdata[15:0];
    end
  end

  // effective address by r/m and mode
  function automatic logic [15:0] ea_calc(input logic [7:0] m, input logic [15:0] d,
                                          input logic [15:0] base_v, input logic [15:0] bptr_v,
                                          input logic [15:0] src_v, input logic [15:0] dst_v);
    logic [15:0] b;
    b = 16'h0000;
    if (m[7:6] == 2'b00 && m[2:0] == 3'b110)
      return d;
    unique case (m[2:0])
      3'd0: b = base_v + src_v;
      3'd1: b = base_v + dst_v;
      3'd2: b = bptr_v + src_v;
      3'd3: b = bptr_v + dst_v;
      3'd4: b = src_v;
      3'd5: b = dst_v;
      3'd6: b = bptr_v;
      3'd7: b = base_v;
    endcase
    return b + d;
  endfunction

  // results of the last instruction and its one-cycle strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= '0;
      ea_r <= cctd_pkg::RST_WORD;
      target_r <= cctd_pkg::RST_WORD;
      operand_r <= cctd_pkg::RST_WORD;
      regval_r <= cctd_pkg::RST_WORD;
      done <= 1'b0;
      ext_handoff <= 1'b0;
      sw_int_req <= 1'b0;
      sw_int_vec <= 8'h00;
    end
    else
    begin
      done <= exec;
      ext_handoff <= exec && kind_r == cctd_pkg::K_HANDOFF;
      sw_int_req <= exec && kind_r == cctd_pkg::K_INT && ex_taken;
      status_r.busy <= (state_nxt != cctd_pkg::ST_OPCODE) | lock_pend_r | seg_pend_r;
      if (exec)
      begin
        if (kind_r == cctd_pkg::K_INT)
          sw_int_vec <= ex_operand[7:0];
        status_r.kind <= kind_r;
        status_r.taken <= ex_taken;
        status_r.lock <= lock_pend_r;
        status_r.seg_valid <= seg_pend_r;
        status_r.seg <= seg_code_r;
        status_r.w <= op_r[0];
        status_r.d <= (kind_r == cctd_pkg::K_ALU) & op_r[1];
        status_r.mode <= modrm_r[7:6];
        status_r.reg_f <= modrm_r[5:3];
        status_r.rm <= modrm_r[2:0];
        status_r.cnt_sel <= (kind_r == cctd_pkg::K_SHIFT) & op_r[1];
        ea_r <= (modrm_r[7:6] == 2'b11) ? cctd_pkg::RST_WORD
              : ea_calc(modrm_r, disp_r, gpr_r[cctd_pkg::RC_BASE], gpr_r[cctd_pkg::RC_BPTR],
                        gpr_r[cctd_pkg::RC_SRC], gpr_r[cctd_pkg::RC_DST]);
        target_r <= ex_ip;
        operand_r <= ex_operand;
        regval_r <= reg_read(modrm_r[5:3], op_r[0], gpr_r[modrm_r[5:3]], gpr_r[{1'b0, modrm_r[4:3]}]);
      end
    end
  end

  // apb slave: zero wait states, error on unmapped or unaligned address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (gpr_hit)
          prdata <= {16'h0000, gpr_r[gpr_idx]};
        else
        begin
          unique case (paddr)
            cctd_pkg::REG_CTRL: prdata <= {31'h0000_0000, run_r};
            cctd_pkg::REG_IP: prdata <= {16'h0000, ip_r};
            cctd_pkg::REG_FLAGS: prdata <= {16'h0000, flags_r};
            cctd_pkg::REG_STATUS: prdata <= {11'h000, status_r};
            cctd_pkg::REG_EA: prdata <= {16'h0000, ea_r};
            cctd_pkg::REG_TARGET: prdata <= {16'h0000, target_r};
            cctd_pkg::REG_OPERAND: prdata <= {16'h0000, operand_r};
            cctd_pkg::REG_REGVAL: prdata <= {16'h0000, regval_r};
            default: pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### hw/cctd_pkg.sv
`default_nettype none
package cctd_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IP = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_EA = 8'h10;
  localparam logic [7:0] REG_TARGET = 8'h14;
  localparam logic [7:0] REG_OPERAND = 8'h18;
  localparam logic [7:0] REG_REGVAL = 8'h1C;
  localparam logic [7:0] REG_GPR_BASE = 8'h20;
  localparam logic [7:0] REG_GPR_LAST = 8'h3C;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic RST_RUN = 1'b0;

  // flag word bit positions and the mask of defined bits
  localparam int unsigned FLG_CARRY = 0;
  localparam int unsigned FLG_PARITY = 2;
  localparam int unsigned FLG_AUX = 4;
  localparam int unsigned FLG_ZERO = 6;
  localparam int unsigned FLG_SIGN = 7;
  localparam int unsigned FLG_TRAP = 8;
  localparam int unsigned FLG_IE = 9;
  localparam int unsigned FLG_DIR = 10;
  localparam int unsigned FLG_OVF = 11;
  localparam logic [15:0] FLAG_MASK = 16'h0FD5;

  // general register codes
  localparam logic [2:0] RC_COUNT = 3'h1;
  localparam logic [2:0] RC_BASE = 3'h3;
  localparam logic [2:0] RC_STACK = 3'h4;
  localparam logic [2:0] RC_BPTR = 3'h5;
  localparam logic [2:0] RC_SRC = 3'h6;
  localparam logic [2:0] RC_DST = 3'h7;

  // opcodes
  localparam logic [7:0] OP_LOOP = 8'hE2;
  localparam logic [7:0] OP_LOOP_EQ = 8'hE1;
  localparam logic [7:0] OP_LOOP_NE = 8'hE0;
  localparam logic [7:0] OP_JCXZ = 8'hE3;
  localparam logic [7:0] OP_INT_N = 8'hCD;
  localparam logic [7:0] OP_INT_3 = 8'hCC;
  localparam logic [7:0] OP_INT_OVF = 8'hCE;
  localparam logic [7:0] OP_CARRY_CPL = 8'hF5;
  localparam logic [7:0] OP_CARRY_SET = 8'hF9;
  localparam logic [7:0] OP_IE_CLEAR = 8'hFA;
  localparam logic [7:0] OP_LOCK = 8'hF0;
  localparam logic [7:0] OP_JMP_SHORT = 8'hEB;
  localparam logic [7:0] OP_RETURN = 8'hC3;
  localparam logic [7:0] OP_RETURN_IMM = 8'hC2;
  localparam logic [7:0] OP_RETURN_FAR_IMM = 8'hCA;
  localparam logic [7:0] INT3_VECTOR = 8'h03;
  localparam logic [15:0] SHIFT_ONE = 16'h0001;
  localparam logic [15:0] POP_BYTES = 16'h0002;

  // decoder states, gray along the full path from ST_OPCODE to ST_EXEC
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_MODRM = 3'b001,
    ST_DISP_LO = 3'b011,
    ST_DISP_HI = 3'b010,
    ST_IMM_LO = 3'b110,
    ST_IMM_HI = 3'b111,
    ST_EXEC = 3'b101
  } cctd_state_t;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_JCC = 4'h1,
    K_LOOP = 4'h2,
    K_JCXZ = 4'h3,
    K_INT = 4'h4,
    K_JMPS = 4'h5,
    K_RETURN = 4'h6,
    K_FLAG = 4'h7,
    K_HANDOFF = 4'h8,
    K_ALU = 4'h9,
    K_IMMGRP = 4'hA,
    K_SHIFT = 4'hB,
    K_UNKNOWN = 4'hC
  } cctd_kind_t;

  // what an opcode byte needs to follow it
  typedef struct packed {
    logic has_modrm;
    logic [1:0] imm_n;
    cctd_kind_t kind;
  } cctd_opinfo_t;

  // result of the last decoded instruction, as read from the status register
  typedef struct packed {
    logic busy;
    logic cnt_sel;
    logic [2:0] rm;
    logic [2:0] reg_f;
    logic [1:0] mode;
    logic d;
    logic w;
    logic [1:0] seg;
    logic seg_valid;
    logic lock;
    logic taken;
    cctd_kind_t kind;
  } cctd_status_t;

endpackage
`default_nettype wire
